// File: wdrt_pkg.sv
// package for the watchdog refresh/time-out block
// assumes a single 200 MHz system clock domain
package wdrt_pkg;
   // ---------------------------------------------------------------
   // counter geometry and reset values
   // ---------------------------------------------------------------
   localparam int          CNT_W       = 24;
   localparam logic [23:0] CNT_ZERO    = 24'h000000;
   localparam logic [23:0] CNT_WRAP    = 24'h0fffff;
   localparam logic [23:0] RELOAD_RST  = 24'h00ffff;
   localparam int          TICK_DIV    = 1;
   // ---------------------------------------------------------------
   // time-out response encoding
   // ---------------------------------------------------------------
   localparam logic        RESP_IRQ    = 1'b0;
   localparam logic        RESP_RESET  = 1'b1;
endpackage

// File: wdrt_tick.sv
// count tick prescaler for the watchdog counter
// assumes sys_clk domain, tick is one cycle wide, or held high every cycle when DIV is 1
`timescale 1ns/1ps
module wdrt_tick #(
   parameter int DIV = 1
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // tick out
   output logic      tick
);
   localparam int PW = (DIV > 1) ? $clog2(DIV) : 1;
   logic [PW-1:0] cnt_q;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (cnt_q == PW'(DIV - 1)) begin
         cnt_q <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick  <= 1'b0;
      end
   end
endmodule

// File: wdrt_watchdog.sv
// watchdog down-counter with refresh and time-out response
// assumes processor, interrupt and reset controllers on plain ports
`timescale 1ns/1ps
// Function
// - on first enable, load counter from reload value before counting
// - decrement counter toward zero each tick unless refreshed
// - refresh instruction reloads counter, then counting resumes
// - under debug, counter is refreshed continuously, no time-out
// - time-out signalled when a tick would take the counter from one to zero
// - option bit selects interrupt or system reset on time-out
// - interrupt mode raises request and sets watchdog status flag
// - after interrupt time-out, counter loads CNT_WRAP (24'h0fffff), no reload
// - status read clears watchdog flag; software reads before irq clear
// - stop-mode time-out in interrupt mode starts recovery and interrupt
// - stop-mode time-out sets watchdog flag and stop-recovery flag; here in interrupt mode only, a reset-mode time-out sets neither
// - stop-mode interrupt stays pending until recovery completes
module wdrt_watchdog #(
   parameter int TICK_DIV = wdrt_pkg::TICK_DIV
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // control
   input  wire logic        wdt_enable,
   input  wire logic [23:0] reload_value,
   input  wire logic        watchdog_refresh_op,
   input  wire logic        debug_active,
   input  wire logic        timeout_response_select,
   input  wire logic        stop_mode,
   input  wire logic        recovery_done,
   // reset status and interrupt
   input  wire logic        reset_cause_rd,
   input  wire logic        irq_ack,
   output logic             reset_cause_wdt_q,
   output logic             reset_cause_stop_q,
   output logic             wdt_irq_q,
   output logic             stop_recovery_q,
   output logic             sys_reset_req_q,
   // state
   output logic [23:0]      count_q
);
   // ---------------------------------------------------------------
   // count tick
   // ---------------------------------------------------------------
   logic tick;
   logic enabled_q;
   logic timeout;
   logic pend_stop_q;

   wdrt_tick #(.DIV(TICK_DIV)) u_tick (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .tick    (tick)
   );

   // ---------------------------------------------------------------
   // down-counter
   // ---------------------------------------------------------------
   // time-out when a tick would take the counter from one to zero
   assign timeout = enabled_q && !debug_active && !watchdog_refresh_op && tick
                    && (count_q == 24'h000001);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         enabled_q <= 1'b0;
         count_q   <= wdrt_pkg::RELOAD_RST;
      end else begin
         enabled_q <= wdt_enable;
         if (wdt_enable && !enabled_q) begin
            count_q <= reload_value;
         end else if (enabled_q && (debug_active || watchdog_refresh_op)) begin
            count_q <= reload_value;
         end else if (timeout) begin
            // reset mode also reinitialises via the system reset
            count_q <= wdrt_pkg::CNT_WRAP;
         end else if (enabled_q && tick && count_q != wdrt_pkg::CNT_ZERO) begin
            count_q <= count_q - 24'h000001;
         end
      end
   end

   // ---------------------------------------------------------------
   // time-out response
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sys_reset_req_q <= 1'b0;
      end else begin
         sys_reset_req_q <= timeout
                            && (timeout_response_select == wdrt_pkg::RESP_RESET);
      end
   end

   // status flags: set wins over read-clear
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reset_cause_wdt_q  <= 1'b0;
         reset_cause_stop_q <= 1'b0;
      end else begin
         if (timeout && timeout_response_select == wdrt_pkg::RESP_IRQ) begin
            reset_cause_wdt_q <= 1'b1;
         end else if (reset_cause_rd) begin
            reset_cause_wdt_q <= 1'b0;
         end
         if (timeout && timeout_response_select == wdrt_pkg::RESP_IRQ && stop_mode) begin
            reset_cause_stop_q <= 1'b1;
         end else if (reset_cause_rd) begin
            reset_cause_stop_q <= 1'b0;
         end
      end
   end

   // interrupt request and stop-mode recovery
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdt_irq_q       <= 1'b0;
         stop_recovery_q <= 1'b0;
         pend_stop_q     <= 1'b0;
      end else begin
         if (timeout && timeout_response_select == wdrt_pkg::RESP_IRQ) begin
            wdt_irq_q <= 1'b1;
         end else if (irq_ack && !pend_stop_q) begin
            wdt_irq_q <= 1'b0;
         end
         if (timeout && timeout_response_select == wdrt_pkg::RESP_IRQ && stop_mode) begin
            stop_recovery_q <= 1'b1;
            pend_stop_q     <= 1'b1;
         end else if (recovery_done) begin
            stop_recovery_q <= 1'b0;
            pend_stop_q     <= 1'b0;
         end
      end
   end
endmodule

// File: wdrt_sva.sv
// checker for the watchdog counter
// sees only the ports of wdrt_watchdog
`timescale 1ns/1ps
module wdrt_sva #(
   parameter int TICK_DIV = 1
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // control
   input  wire logic        wdt_enable,
   input  wire logic [23:0] reload_value,
   input  wire logic        watchdog_refresh_op,
   input  wire logic        debug_active,
   input  wire logic        timeout_response_select,
   input  wire logic        stop_mode,
   input  wire logic        recovery_done,
   // reset status and interrupt
   input  wire logic        reset_cause_rd,
   input  wire logic        irq_ack,
   input  wire logic        reset_cause_wdt_q,
   input  wire logic        reset_cause_stop_q,
   input  wire logic        wdt_irq_q,
   input  wire logic        stop_recovery_q,
   input  wire logic        sys_reset_req_q,
   // state
   input  wire logic [23:0] count_q
);
   logic en_q;
   logic run;
   logic to;
   // enable as seen one cycle ago, same as the counter's own enable
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         en_q <= 1'b0;
      end else begin
         en_q <= wdt_enable;
      end
   end
   // exact only while every cycle is a count tick
   assign run = (TICK_DIV == 1) && en_q && !watchdog_refresh_op && !debug_active;
   assign to  = run && (count_q == 24'h000001);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   property p_ld; $rose(wdt_enable) |-> ##[1:2] count_q == reload_value; endproperty
   a_ld: assert property (p_ld) else $error("no load");
   property p_dec; run && count_q > 24'h1 |=> count_q == $past(count_q) - 24'h1; endproperty
   a_dec: assert property (p_dec) else $error("no decrement");
   property p_ref; en_q && watchdog_refresh_op |=> count_q == $past(reload_value);
   endproperty
   a_ref: assert property (p_ref) else $error("no refresh");
   property p_dbg; debug_active |=> !sys_reset_req_q && !$rose(wdt_irq_q); endproperty
   a_dbg: assert property (p_dbg) else $error("debug timeout");
   property p_irq; to && !timeout_response_select |=>
      wdt_irq_q && reset_cause_wdt_q && count_q == wdrt_pkg::CNT_WRAP; endproperty
   a_irq: assert property (p_irq) else $error("bad irq timeout");
   property p_rst; to && timeout_response_select |=> sys_reset_req_q ##1 !sys_reset_req_q;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset pulse");
   property p_clr; reset_cause_rd && !to |=> !reset_cause_wdt_q; endproperty
   a_clr: assert property (p_clr) else $error("flag kept");
   property p_stp; to && !timeout_response_select && stop_mode |=>
      stop_recovery_q && reset_cause_stop_q; endproperty
   a_stp: assert property (p_stp) else $error("no recovery");
   property p_pnd; stop_recovery_q && wdt_irq_q && !recovery_done |=> wdt_irq_q; endproperty
   a_pnd: assert property (p_pnd) else $error("irq lost");
   c_irq: cover property (to && !timeout_response_select);
   c_rst: cover property (to && timeout_response_select);
   c_rec: cover property (stop_recovery_q && recovery_done);
endmodule
bind wdrt_watchdog wdrt_sva #(.TICK_DIV(TICK_DIV)) u_sva (.*);

// File: wdrt_partner.sv
// model of processor, interrupt and reset controllers
// answers DLY+1 cycles after a request
`timescale 1ns/1ps
module wdrt_partner #(parameter int DLY = 3) (input wire logic clk, rst, irq, rec_req,
   output logic rd, ack, done);
   int n;
   always_ff @(posedge clk or posedge rst) if (rst) begin
      n <= 0; rd <= 0; ack <= 0; done <= 0;
   end else begin
      ack <= rd;
      rd <= irq && !rec_req && n == DLY;
      done <= rec_req && n == DLY;
      n <= ((irq || rec_req) && n < DLY + 2) ? n + 1 : 0;
   end
endmodule

// File: wdrt_watchdog_bench.sv
// bench for wdrt_watchdog
// partner model answers interrupts and recovery
`timescale 1ns/1ps
module wdrt_watchdog_bench;
   logic sys_clk = 0, sys_rst = 1, wdt_enable = 0, watchdog_refresh_op = 0, debug_active = 0;
   logic timeout_response_select = 0, stop_mode = 0, recovery_done, reset_cause_rd, irq_ack;
   logic reset_cause_wdt_q, reset_cause_stop_q, wdt_irq_q, stop_recovery_q, sys_reset_req_q;
   logic [23:0] reload_value = 24'h3, count_q;
   int failures = 0, comparisons = 0, n;
   logic [31:0] rows [3] = '{{8'h14, 24'h3}, {8'h01, 24'h1}, {8'h14, 24'h8}};
   wdrt_watchdog uut (.*);
   wdrt_partner u_cpu (.clk(sys_clk), .rst(sys_rst), .irq(wdt_irq_q),
      .rec_req(stop_recovery_q), .rd(reset_cause_rd), .ack(irq_ack), .done(recovery_done));
   initial forever #2.5 sys_clk = ~sys_clk;
   function automatic logic [23:0] fl();
      return {19'h0, reset_cause_wdt_q, reset_cause_stop_q, wdt_irq_q, stop_recovery_q,
         sys_reset_req_q};
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      if (failures == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic restart(input logic [23:0] r, input logic m);
      @(negedge sys_clk) sys_rst = 1;
      wdt_enable = 0; reload_value = r; timeout_response_select = m;
      repeat (5) @(negedge sys_clk);
      sys_rst = 0;
      chk(count_q, wdrt_pkg::RELOAD_RST);
      chk(fl(), 24'h0);
      @(negedge sys_clk) wdt_enable = 1;
   endtask
   task automatic wait_to;
      n = 0;
      while (!(wdt_irq_q || sys_reset_req_q)) begin
         @(negedge sys_clk);
         if (++n > 40) begin failures++; print_verdict; end
      end
   endtask
   initial begin
      foreach (rows[i]) begin
         restart(rows[i][23:0], rows[i][24]);
         wait_to;
         chk(count_q, wdrt_pkg::CNT_WRAP);
         chk(fl() & 24'h1f, {16'h0, rows[i][31:24]});
         repeat (8) @(negedge sys_clk);
         chk(fl() & 24'h1f, 24'h0);
      end
      restart(24'h5, 1'b0);
      repeat (3) @(negedge sys_clk);
      chk(count_q, 24'h3);
      watchdog_refresh_op = 1;
      @(negedge sys_clk) watchdog_refresh_op = 0;
      chk(count_q, 24'h5);
      debug_active = 1;
      repeat (12) @(negedge sys_clk);
      chk(fl() & 24'h7, 24'h0);
      chk(count_q, 24'h5);
      debug_active = 0;
      restart(24'h2, 1'b0);
      stop_mode = 1;
      wait_to;
      chk(fl() & 24'h1e, 24'h1e);
      stop_mode = 0;
      repeat (3) @(negedge sys_clk);
      chk(fl() & 24'h4, 24'h4);
      print_verdict;
   end
endmodule
